// >>> common/srsm_pkg.sv
// Constants for the secondary receive slot mapper: register indices,
// field layout, reset values, format codes and buffer sizing.
// Assumes a 32-bit Avalon-MM host and synchronous serial audio pins.
//
// Overview of operation
// R1: Map register bits 7-6 are reserved, read zero, and writes to them are ignored
// R2: Channel 1 enable bit 5: clear takes no input, set feeds DAC channel 1
// R3: Channel 2 enable bit 5: clear disables, set routes its slot to DAC channel 2
// R4: Slot field bits 4-0 name the source slot; TDM uses slots 0 to 31
// R5: I2S or LJ: field values 0 to 15 pick left-half slot 0 to 15
// R6: I2S or LJ: field values 16 to 31 pick right-half slot value minus 16
// R7: Reset: channel 1 map reads 0x00, channel 2 reads 0x01, both disabled
// R8: Channel 3 map register sits at index 0x2A and resets to 0x02
// R9: Channel 3 map has the same layout and feeds DAC channel 3
// R10: Per-channel pin select: clear takes primary data input, set takes second input
// R11: Enabled channel delivers its full slot word once per frame; disabled delivers none
package srsm_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_PIN_SEL = 8'h27;
    localparam logic [7:0] IDX_CH1_MAP = 8'h28;
    localparam logic [7:0] IDX_CH2_MAP = 8'h29;
    localparam logic [7:0] IDX_CH3_MAP = 8'h2A;
    localparam logic [7:0] IDX_FORMAT = 8'h30;
    localparam logic [7:0] IDX_STATUS = 8'h31;
    // Reset values
    localparam logic [5:0] RST_CH1_MAP = 6'h00;
    localparam logic [5:0] RST_CH2_MAP = 6'h01;
    localparam logic [5:0] RST_CH3_MAP = 6'h02;
    localparam logic [2:0] RST_PIN_SEL = 3'h0;
    localparam logic [1:0] RST_FORMAT = 2'h0;
    // Map register layout
    localparam int MAP_EN_BIT = 5;
    localparam int MAP_SLOT_W = 5;
    localparam int MAP_STORE_W = 6;
    // Channel count and half-frame slot index width
    localparam int NUM_CH = 3;
    localparam int HALF_SLOT_W = 4;
    // Serial format codes
    localparam logic [1:0] FMT_TDM = 2'h0;
    localparam logic [1:0] FMT_I2S = 2'h1;
    localparam logic [1:0] FMT_LJ = 2'h2;
    // Status register fields
    localparam int STAT_OVF_BIT = 0;
    localparam int STAT_PEND_LSB = 1;
    // Defaults for slot width and buffer depth
    localparam int DEF_WORD_LOG2 = 5;
    localparam int DEF_FIFO_DEPTH = 8;
endpackage

// >>> hdl/srsm_top.sv
// Slot mapper for the secondary serial audio receive port, channels 1-3,
// with its Avalon-MM register slave and an output word FIFO.
// Assumes bit clock, frame sync and data pins are synchronous to
// I_REF_CLK and much slower than it.

// Word FIFO with registered storage and honest full and empty
module srsm_fifo #(
    parameter int WIDTH = 34,
    parameter int DEPTH = srsm_pkg::DEF_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Filling side
    input wire logic i_in_valid,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_in_ready,
    // Draining side
    output logic o_out_valid,
    output logic [WIDTH-1:0] o_out_data,
    input wire logic i_out_ready
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } srsm_fifo_t;

    srsm_fifo_t st_reg;
    srsm_fifo_t st_next;
    logic push;
    logic pop;

    // Flags and read port
    assign o_in_ready = (st_reg.cnt != (AW+1)'(DEPTH));
    assign o_out_valid = (st_reg.cnt != '0);
    assign o_out_data = st_reg.mem[st_reg.rp];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    // Pointer and count update
    always_comb begin
        st_next = st_reg;
        if (push) begin
            st_next.mem[st_reg.wp] = i_in_data;
            st_next.wp = (st_reg.wp == AW'(DEPTH - 1)) ? '0 :
                st_reg.wp + 1'b1;
        end
        if (pop) begin
            st_next.rp = (st_reg.rp == AW'(DEPTH - 1)) ? '0 :
                st_reg.rp + 1'b1;
        end
        if (push && !pop) begin
            st_next.cnt = st_reg.cnt + 1'b1;
        end else if (pop && !push) begin
            st_next.cnt = st_reg.cnt - 1'b1;
        end
    end

    // State register
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule

module srsm_top #(
    parameter int WORD_LOG2 = srsm_pkg::DEF_WORD_LOG2,
    parameter int FIFO_DEPTH = srsm_pkg::DEF_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic I_REF_CLK,
    input wire logic I_RSTN,
    // Avalon-MM register slave
    input wire logic [9:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [31:0] I_AVS_WRITEDATA,
    input wire logic [3:0] I_AVS_BYTEENABLE,
    output logic [31:0] O_AVS_READDATA,
    output logic O_AVS_WAITREQUEST,
    // Serial audio receive pins
    input wire logic I_BCLK,
    input wire logic I_FSYNC,
    input wire logic I_DIN,
    input wire logic I_SECOND_SERIAL_INPUT_PIN,
    // DAC channel word stream
    output logic O_DAC_VALID,
    output logic [1:0] O_DAC_CHANNEL,
    output logic [(1<<WORD_LOG2)-1:0] O_DAC_DATA,
    input wire logic I_DAC_READY
);
    localparam int WORD_W = 1 << WORD_LOG2;
    localparam int IDX_W = WORD_LOG2 + srsm_pkg::MAP_SLOT_W + 1;
    localparam int NCH = srsm_pkg::NUM_CH;
    localparam int FW = WORD_W + 2;

    typedef struct packed {
        logic waitreq;
        logic [31:0] rdata;
        logic [NCH-1:0][srsm_pkg::MAP_STORE_W-1:0] map;
        logic [NCH-1:0] pin_sel;
        logic [1:0] fmt;
        logic ovf;
        logic bclk_d;
        logic fs_d1;
        logic fs_d2;
        logic framed;
        logic [IDX_W-1:0] cnt;
        logic [NCH-1:0][WORD_W-1:0] sh;
        logic [NCH-1:0] pend;
        logic [NCH-1:0][WORD_W-1:0] pdata;
        logic out_valid;
        logic [1:0] out_ch;
        logic [WORD_W-1:0] out_data;
    } srsm_state_t;

    srsm_state_t st_reg;
    srsm_state_t st_next;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic [FW-1:0] fifo_in_data;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [FW-1:0] fifo_out_data;
    logic [1:0] sel;

    // Pending channel word with the lowest channel number goes to the FIFO first
    always_comb begin
        sel = 2'h0;
        for (int k = NCH - 1; k >= 0; k--) begin
            if (st_reg.pend[k]) begin
                sel = 2'(k);
            end
        end
    end

    assign fifo_in_valid = |st_reg.pend;
    assign fifo_in_data = {2'(sel + 2'h1), st_reg.pdata[sel]};
    assign fifo_out_ready = !st_reg.out_valid || I_DAC_READY;

    srsm_fifo #(
        .WIDTH(FW),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_clk(I_REF_CLK),
        .i_rstn(I_RSTN),
        .i_in_valid(fifo_in_valid),
        .i_in_data(fifo_in_data),
        .o_in_ready(fifo_in_ready),
        .o_out_valid(fifo_out_valid),
        .o_out_data(fifo_out_data),
        .i_out_ready(fifo_out_ready)
    );

    // Bus slave, frame tracking, slot capture and output stage
    always_comb begin
        logic [7:0] idx_addr;
        logic [7:0] rd_byte;
        logic rise;
        logic tdm;
        logic eff;
        logic effp;
        logic start;
        logic in_range;
        logic last;
        logic din_bit;
        logic [IDX_W-1:0] idx;
        logic [srsm_pkg::MAP_SLOT_W-1:0] slot;
        logic [srsm_pkg::MAP_SLOT_W-1:0] code;
        logic [WORD_W-1:0] word;
        idx_addr = I_AVS_ADDRESS[9:2];
        rd_byte = 8'h00;
        rise = I_BCLK && !st_reg.bclk_d;
        tdm = (st_reg.fmt != srsm_pkg::FMT_I2S) &&
            (st_reg.fmt != srsm_pkg::FMT_LJ);
        eff = 1'b0;
        effp = 1'b0;
        start = 1'b0;
        in_range = 1'b0;
        last = 1'b0;
        din_bit = 1'b0;
        idx = '0;
        slot = '0;
        code = '0;
        word = '0;
        st_next = st_reg;

        // One wait cycle, then the answer
        st_next.waitreq = !((I_AVS_READ || I_AVS_WRITE) && st_reg.waitreq);
        if (I_AVS_READ && st_reg.waitreq) begin
            unique case (idx_addr)
                srsm_pkg::IDX_PIN_SEL: rd_byte = {5'h00, st_reg.pin_sel};
                srsm_pkg::IDX_CH1_MAP: rd_byte = {2'b00, st_reg.map[0]}; // R1
                srsm_pkg::IDX_CH2_MAP: rd_byte = {2'b00, st_reg.map[1]};
                srsm_pkg::IDX_CH3_MAP: rd_byte = {2'b00, st_reg.map[2]};
                srsm_pkg::IDX_FORMAT: rd_byte = {6'h00, st_reg.fmt};
                srsm_pkg::IDX_STATUS: rd_byte = {4'h0, st_reg.pend,
                    st_reg.ovf};
                default: rd_byte = 8'h00;
            endcase
            st_next.rdata = {24'h000000, rd_byte};
        end
        // Writes land at the edge where waitrequest is seen low
        if (I_AVS_WRITE && !st_reg.waitreq && I_AVS_BYTEENABLE[0]) begin
            unique case (idx_addr)
                srsm_pkg::IDX_PIN_SEL:
                    st_next.pin_sel = I_AVS_WRITEDATA[NCH-1:0];
                srsm_pkg::IDX_CH1_MAP: st_next.map[0] = I_AVS_WRITEDATA[5:0];
                srsm_pkg::IDX_CH2_MAP: st_next.map[1] = I_AVS_WRITEDATA[5:0];
                srsm_pkg::IDX_CH3_MAP:
                    st_next.map[2] = I_AVS_WRITEDATA[5:0]; // R9
                srsm_pkg::IDX_FORMAT: st_next.fmt = I_AVS_WRITEDATA[1:0];
                srsm_pkg::IDX_STATUS: begin
                    if (I_AVS_WRITEDATA[srsm_pkg::STAT_OVF_BIT]) begin
                        st_next.ovf = 1'b0;
                    end
                end
                default: ;
            endcase
        end

        // Hand the selected pending word to the FIFO
        if (fifo_in_valid && fifo_in_ready) begin
            st_next.pend[sel] = 1'b0;
        end

        // Serial side: act on each bit clock rising edge
        st_next.bclk_d = I_BCLK;
        if (rise) begin
            st_next.fs_d1 = I_FSYNC;
            st_next.fs_d2 = st_reg.fs_d1;
            // I2S left half is frame sync low, one bit late
            if (st_reg.fmt == srsm_pkg::FMT_I2S) begin
                eff = !st_reg.fs_d1;
                effp = !st_reg.fs_d2;
            end else begin
                eff = I_FSYNC;
                effp = st_reg.fs_d1;
            end
            start = tdm ? (eff && !effp) : (eff != effp);
            idx = start ? '0 : st_reg.cnt;
            if (start) begin
                st_next.framed = 1'b1;
            end
            if (idx != '1) begin
                st_next.cnt = idx + 1'b1;
            end
            slot = idx[WORD_LOG2 +: srsm_pkg::MAP_SLOT_W];
            last = &idx[WORD_LOG2-1:0];
            if (tdm) begin
                code = slot; // R4
                in_range = !idx[IDX_W-1];
            end else begin
                // Left half maps to 0-15, right half to 16-31
                code = {!eff, slot[srsm_pkg::HALF_SLOT_W-1:0]}; // R5 R6
                in_range = !idx[IDX_W-1] && !slot[srsm_pkg::MAP_SLOT_W-1];
            end
            for (int c = 0; c < NCH; c++) begin
                din_bit = st_reg.pin_sel[c] ? // R10
                    I_SECOND_SERIAL_INPUT_PIN : I_DIN;
                if ((st_reg.framed || start) && in_range &&
                    st_reg.map[c][srsm_pkg::MAP_EN_BIT] && // R2 R3 R9
                    st_reg.map[c][srsm_pkg::MAP_SLOT_W-1:0] == code) begin
                    word = {st_reg.sh[c][WORD_W-2:0], din_bit};
                    st_next.sh[c] = word;
                    // Whole word once per frame; a full holding slot drops it
                    if (last) begin // R11
                        if (st_next.pend[c]) begin
                            st_next.ovf = 1'b1;
                        end else begin
                            st_next.pend[c] = 1'b1;
                            st_next.pdata[c] = word;
                        end
                    end
                end
            end
        end

        // Output register stage toward the DAC paths
        if (st_reg.out_valid && I_DAC_READY) begin
            st_next.out_valid = 1'b0;
        end
        if (fifo_out_valid && fifo_out_ready) begin
            st_next.out_valid = 1'b1;
            st_next.out_ch = fifo_out_data[FW-1 -: 2];
            st_next.out_data = fifo_out_data[WORD_W-1:0];
        end
    end

    // State register with documented defaults
    always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            st_reg <= '0;
            st_reg.waitreq <= 1'b1;
            st_reg.map[0] <= srsm_pkg::RST_CH1_MAP; // R7
            st_reg.map[1] <= srsm_pkg::RST_CH2_MAP; // R7
            st_reg.map[2] <= srsm_pkg::RST_CH3_MAP; // R8
            st_reg.pin_sel <= srsm_pkg::RST_PIN_SEL;
            st_reg.fmt <= srsm_pkg::RST_FORMAT;
        end else begin
            st_reg <= st_next;
        end
    end

    // Ports straight from the state register
    assign O_AVS_READDATA = st_reg.rdata;
    assign O_AVS_WAITREQUEST = st_reg.waitreq;
    assign O_DAC_VALID = st_reg.out_valid;
    assign O_DAC_CHANNEL = st_reg.out_ch;
    assign O_DAC_DATA = st_reg.out_data;
endmodule

// >>> sim/secondary_rx_slot_mapper_tb.sv
// Testbench for the slot mapper: registers, mapping, halves, buffer.
// Assumes srsm_top with 16-bit slots and the host model beside it.
module secondary_rx_slot_mapper_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // Bench signals
    logic clk = 1'b0, rstn = 1'b0, rd = 1'b0, wr = 1'b0, dready = 1'b1;
    logic [9:0] addr = 10'h000;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata, sv;
    logic wait_req, bclk, fsync, din, second_serial_input_pin, dvalid;
    logic [1:0] dch;
    logic [15:0] ddata;
    logic [17:0] got_q[$];
    int failures = 0, samples_checked = 0;
    // Clock of 5 ns
    initial begin
        forever #2.5 clk = ~clk;
    end
    // Design with 16-bit slots
    srsm_top #(.WORD_LOG2(4), .FIFO_DEPTH(8)) i_dut (
        .I_REF_CLK(clk), .I_RSTN(rstn), .I_AVS_ADDRESS(addr),
        .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata),
        .I_AVS_BYTEENABLE(4'hF), .O_AVS_READDATA(rdata),
        .O_AVS_WAITREQUEST(wait_req), .I_BCLK(bclk), .I_FSYNC(fsync),
        .I_DIN(din),
        .I_SECOND_SERIAL_INPUT_PIN(second_serial_input_pin),
        .O_DAC_VALID(dvalid),
        .O_DAC_CHANNEL(dch), .O_DAC_DATA(ddata), .I_DAC_READY(dready));
    srsm_host_model i_host (.i_clk(clk), .o_bclk(bclk), .o_fsync(fsync),
        .o_din(din), .o_second_serial_input_pin(second_serial_input_pin));
    // Sink collects every accepted DAC word
    always @(posedge clk) begin
        if (dvalid === 1'b1 && dready === 1'b1) got_q.push_back({dch, ddata});
    end
    // Compare and count
    task check(input string what, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One Avalon transfer, held until waitrequest is sampled low
    task bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
        @(posedge clk);
        addr <= {idx, 2'h0};
        wdata <= {24'h0, d};
        rd <= !w;
        wr <= w;
        do begin
            @(posedge clk);
        end while (wait_req !== 1'b0);
        sv = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        check("register", sv, {24'h0, exp});
    endtask
    // Oldest delivered word against channel and data
    task want(input logic [1:0] ch, input logic [15:0] w);
        logic [17:0] g;
        g = (got_q.size() > 0) ? got_q.pop_front() : 18'h3FFFF;
        check("dac word", {14'h0, g}, {14'h0, ch, w});
    endtask
    task frame(input logic [1:0] fmt, input int n);
        i_host.send_frame(fmt, n);
        repeat (40) @(posedge clk);
    endtask
    // Counts, verdict and end of run
    task complete_run;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Watchdog against a hung handshake
    initial begin
        repeat (60000) @(posedge clk);
        failures++;
        complete_run;
    end
    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        rd_chk(8'h28, 8'h00);
        rd_chk(8'h29, 8'h01);
        rd_chk(8'h2A, 8'h02);
        rd_chk(8'h3F, 8'h00);
        $display("test reset done");
        // TDM slots 0, 31 and 2, channel 3 on the second pin
        bus(1'b1, 8'h28, 8'h20);
        bus(1'b1, 8'h29, 8'h3F);
        bus(1'b1, 8'h2A, 8'h22);
        bus(1'b1, 8'h27, 8'h04);
        rd_chk(8'h29, 8'h3F);
        rd_chk(8'h27, 8'h04);
        frame(2'h0, 32);
        want(2'h1, 16'hA000);
        want(2'h3, 16'h5002);
        want(2'h2, 16'hA01F);
        bus(1'b1, 8'h29, 8'h1F);
        frame(2'h0, 32);
        want(2'h1, 16'hA000);
        want(2'h3, 16'h5002);
        check("left over", got_q.size(), 0);
        $display("test tdm done");
        // Left slot 3, right slots 1 and 0 in I2S then LJ
        bus(1'b1, 8'h27, 8'h00);
        bus(1'b1, 8'h28, 8'h23);
        bus(1'b1, 8'h29, 8'h31);
        bus(1'b1, 8'h2A, 8'h30);
        for (int f = 1; f < 3; f++) begin
            bus(1'b1, 8'h30, 8'(f));
            frame(f[1:0], 32);
            want(2'h1, 16'hA003);
            want(2'h3, 16'hA010);
            want(2'h2, 16'hA011);
        end
        $display("test halves done");
        // Stalled sink fills the buffer until words are dropped
        bus(1'b1, 8'h30, 8'h00);
        bus(1'b1, 8'h28, 8'h20);
        bus(1'b1, 8'h29, 8'h21);
        bus(1'b1, 8'h2A, 8'h22);
        dready <= 1'b0;
        repeat (5) frame(2'h0, 4);
        bus(1'b0, 8'h31, 8'h00);
        check("status", sv, 32'h0000000F);
        dready <= 1'b1;
        repeat (80) @(posedge clk);
        check("drained", got_q.size(), 32'h0000000C);
        want(2'h1, 16'hA000);
        bus(1'b1, 8'h31, 8'h01);
        rd_chk(8'h31, 8'h00);
        $display("test buffer done");
        // Reset in mid-run brings the map defaults back
        rstn <= 1'b0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        rd_chk(8'h28, 8'h00);
        rd_chk(8'h29, 8'h01);
        rd_chk(8'h2A, 8'h02);
        rd_chk(8'h27, 8'h00);
        $display("test reset again done");
        complete_run;
    end
endmodule

// >>> sim/srsm_host_model.sv
// Host model driving serial audio frames in TDM, I2S or LJ format.
// Assumes 16-bit slots; slot word is A000 or 5000 plus the slot code.
module srsm_host_model #(parameter int W = 16) (
    // Reference clock
    input wire logic i_clk,
    // Serial pins toward the receiver
    output logic o_bclk,
    output logic o_fsync,
    output logic o_din,
    output logic o_second_serial_input_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle pins at time zero
    initial begin
        o_bclk = 1'b0;
        o_fsync = 1'b0;
        o_din = 1'b0;
        o_second_serial_input_pin = 1'b0;
    end
    // One frame of n slots, two lead bits, clock stopped after it
    task send_frame(input logic [1:0] fmt, input int n);
        int t, h, p;
        logic [15:0] wa, wb;
        t = n * W;
        h = 16 * W;
        for (int b = -2; b < t; b++) begin
            p = (b < 0) ? 0 : b;
            wa = 16'hA000 | 16'(p / W);
            wb = 16'h5000 | 16'(p / W);
            @(posedge i_clk);
            o_bclk <= 1'b0;
            if (fmt == srsm_pkg::FMT_TDM) o_fsync <= (b == 0);
            else if (fmt == srsm_pkg::FMT_I2S) o_fsync <= (b + 1 + t) % t >= h;
            else o_fsync <= (b + t) % t < h;
            o_din <= wa[W - 1 - p % W];
            o_second_serial_input_pin <= wb[W - 1 - p % W];
            repeat (2) @(posedge i_clk);
            o_bclk <= 1'b1;
            @(posedge i_clk);
        end
        @(posedge i_clk);
        o_bclk <= 1'b0;
        o_din <= ~o_din;
        o_second_serial_input_pin <= ~o_second_serial_input_pin;
    endtask
endmodule

// >>> sim/srsm_top_asserts.sv
// Checker for the slot mapper top: bus timing, read masks, DAC hold.
// Assumes it is bound to srsm_top and sees only its ports.
module srsm_top_asserts #(parameter int WORD_LOG2 = 5) (
    // Clock and reset
    input wire logic I_REF_CLK,
    input wire logic I_RSTN,
    // Register bus
    input wire logic [9:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [31:0] O_AVS_READDATA,
    input wire logic O_AVS_WAITREQUEST,
    // DAC word stream
    input wire logic O_DAC_VALID,
    input wire logic [1:0] O_DAC_CHANNEL,
    input wire logic [(1<<WORD_LOG2)-1:0] O_DAC_DATA,
    input wire logic I_DAC_READY
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RSTN);
    // Request, register index and accepted read
    wire req = I_AVS_READ | I_AVS_WRITE;
    wire [7:0] idx = I_AVS_ADDRESS[9:2];
    wire rd_ok = I_AVS_READ & !O_AVS_WAITREQUEST;
    // Exactly one wait cycle, then idle again
    sequence s_one_wait;
        !O_AVS_WAITREQUEST ##1 O_AVS_WAITREQUEST;
    endsequence
    chk_bus_answer: assert property (req && O_AVS_WAITREQUEST |=> s_one_wait)
        else $error("bus answer not one cycle");
    chk_idle_wait: assert property (!req |=> O_AVS_WAITREQUEST)
        else $error("waitrequest low without request");
    chk_rsv_zero: assert property (
        rd_ok && idx inside {8'h28, 8'h29, 8'h2A} |->
        O_AVS_READDATA[31:6] == 26'h0) else $error("reserved bits read set");
    chk_pin_zero: assert property (
        rd_ok && idx == 8'h27 |-> O_AVS_READDATA[31:3] == 29'h0)
        else $error("pin select upper bits set");
    chk_unmapped_zero: assert property (rd_ok &&
        !(idx inside {8'h27, 8'h28, 8'h29, 8'h2A, 8'h30, 8'h31}) |->
        O_AVS_READDATA == 32'h0) else $error("unmapped read not zero");
    chk_dac_hold: assert property (O_DAC_VALID && !I_DAC_READY |=>
        O_DAC_VALID && $stable(O_DAC_CHANNEL) && $stable(O_DAC_DATA))
        else $error("DAC word dropped while stalled");
    chk_dac_chan: assert property (
        O_DAC_VALID |-> O_DAC_CHANNEL inside {2'h1, 2'h2, 2'h3})
        else $error("DAC channel out of range");
    chk_reset_quiet: assert property ($rose(I_RSTN) |->
        O_AVS_WAITREQUEST && !O_DAC_VALID)
        else $error("outputs active at reset release");
endmodule

bind srsm_top srsm_top_asserts #(.WORD_LOG2(WORD_LOG2)) u_chk (
    .I_REF_CLK(I_REF_CLK), .I_RSTN(I_RSTN), .I_AVS_ADDRESS(I_AVS_ADDRESS),
    .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE),
    .O_AVS_READDATA(O_AVS_READDATA), .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST),
    .O_DAC_VALID(O_DAC_VALID), .O_DAC_CHANNEL(O_DAC_CHANNEL),
    .O_DAC_DATA(O_DAC_DATA), .I_DAC_READY(I_DAC_READY));
